// ===== verilog/sefb_bank.sv
/*
  Sensor event flag bank: read-only event and flag registers, plus the
  Hall-effect settings registers and the differential Hall switch logic.
  Assumes all sensing inputs come from logic on CLK (no synchronisers) and
  that a serial bus front end drives the register port on the same clock.
*/
// How it works
// - 0x11 bit0: any CHAN_NEAR/CHAN_CONTACT activity, not antenna flags
// - SAR level bit7 follows detection continuously
// - SAR toggle inverts on event or status change
// - Bit3 from channel-two hysteresis data only
// - Global register read-only, carries other events
// - 0x12 near bits 0-2, contact 4-6
// - Single SAR layout of 0x13
// - Two-antenna layouts of 0x12 and 0x13
// - Channel 4 positive, channel 5 negative
// - Hall channels always combined differentially
// - Hall output compared to near, contact levels
// - Hall field direction reported north/south
// - Optional inverse linearisation of Hall output
`timescale 1ns/100ps

module sefb_bank
  import sefb_pkg::*;
#(
  parameter int HALL_W = 16
)
(
  input  wire logic              CLK,
  input  wire logic              RST_B,
  input  wire logic [7:0]        REG_ADDR,
  input  wire logic              REG_WR_EN,
  input  wire logic [7:0]        REG_WR_DATA,
  output      logic [7:0]        REG_RD_DATA,
  input  wire logic [1:0]        UI_MODE,
  input  wire logic [2:0]        CHAN_NEAR,
  input  wire logic [2:0]        CHAN_CONTACT,
  input  wire logic              SAR_DETECT_LEVEL,
  input  wire logic              SAR_QUALIFIED_EVENT,
  input  wire logic              SAR_QUICK_RELEASE,
  input  wire logic              SAR_MOVEMENT,
  input  wire logic              SAR_FILTER_HALTED,
  input  wire logic              ANT1_NEAR,
  input  wire logic              ANT1_CONTACT,
  input  wire logic              ANT1_DEEP,
  input  wire logic              ANT2_NEAR,
  input  wire logic              ANT2_CONTACT,
  input  wire logic              ANT2_DEEP,
  input  wire logic              HYST_CH2_NEAR,
  input  wire logic              HYST_CH2_CONTACT,
  input  wire logic              HYST_CH2_SIGNED,
  input  wire logic              TEMP_EVENT,
  input  wire logic              SYSTEM_EVENT,
  input  wire logic              POWER_MANAGER_EVENT,
  input  wire logic [HALL_W-1:0] HALL_CH4_POS,
  input  wire logic [HALL_W-1:0] HALL_CH5_NEG,
  output      logic [3:0]        HALL_CHARGE_DIV,
  output      logic [1:0]        HALL_AUTO_TUNING_MODE,
  output      logic [3:0]        HALL_AUTO_TUNING_BASE,
  output      logic [3:0]        HALL_AUTO_TUNING_TARGET,
  output      logic [HALL_W-1:0] HALL_AMPLITUDE,
  output      logic              HALL_NEAR,
  output      logic              HALL_CONTACT,
  output      logic              HALL_SOUTH
);

  // ===========================================================
  // State
  typedef struct packed {
    logic [7:0]        rate_cfg_r;
    logic [7:0]        tuning_cfg_r;
    logic [7:0]        switch_cfg_r;
    logic [7:0]        near_level_r;
    logic [7:0]        contact_level_r;
    logic [HALL_W-1:0] hall_amp_r;
    logic              hall_near_r;
    logic              hall_contact_r;
    logic              hall_south_r;
    logic              hall_toggle_r;
    logic              sar_toggle_r;
    // Detection level of the previous cycle, kept to see a status change
    logic              sar_level_prev_r;
    logic [7:0]        rd_data_r;
  } sefb_state_t;

  sefb_state_t s_r;
  sefb_state_t s_nxt;

  // ===========================================================
  // Helpers
  // Restoring divide of a fixed numerator; a zero amplitude saturates so the
  // linearised value never wraps to a small number near the magnet.
  function automatic logic [HALL_W-1:0] hall_inverse(input logic [HALL_W-1:0] mag);
    logic [HALL_W-1:0] quo;
    logic [HALL_W:0]   rem;
    logic [HALL_W-1:0] numer;
    quo   = '0;
    rem   = '0;
    numer = HALL_W'(SEFB_HALL_INV_NUMER);
    if (mag == '0)
    begin
      quo = '1;
    end
    else
    begin
      for (int i = HALL_W - 1; i >= 0; i--)
      begin
        rem = {rem[HALL_W-1:0], numer[i]};
        if (rem >= {1'b0, mag})
        begin
          rem    = rem - {1'b0, mag};
          quo[i] = 1'b1;
        end
      end
    end
    return quo;
  endfunction

  // Thresholds are 8 bits wide; the shift scales them by 16 within the amplitude
  // range, trading fine resolution near zero for reach
  function automatic logic [HALL_W-1:0] level_scale(input logic [7:0] lvl);
    return HALL_W'({lvl, {SEFB_HALL_THR_SHIFT{1'b0}}});
  endfunction

  // ===========================================================
  // Combinational view of the flags
  // Hall path: one clock of latency from the channel inputs to the outputs
  sefb_ui_mode_t     ui_mode;
  logic [HALL_W:0]   hall_diff;
  logic [HALL_W-1:0] hall_mag;
  logic [HALL_W-1:0] hall_out;
  logic              hall_en;
  logic              near_hit;
  logic              contact_hit;
  logic [7:0]        global_view;
  logic [7:0]        chan_view;
  logic [7:0]        detail_view;
  logic              hall_change;
  logic              sar_change;

  always_comb
  begin
    ui_mode = sefb_ui_mode_t'(UI_MODE);
    hall_en = s_r.switch_cfg_r[SEFB_HS_ENABLE_BIT];
    // Positive plate minus negative plate cancels common-mode disturbance
    hall_diff = {1'b0, HALL_CH4_POS} - {1'b0, HALL_CH5_NEG};
    if (hall_diff[HALL_W])
    begin
      hall_mag = HALL_W'(~hall_diff[HALL_W-1:0] + 1'b1);
    end
    else
    begin
      hall_mag = hall_diff[HALL_W-1:0];
    end
    if (s_r.switch_cfg_r[SEFB_HS_LINEARIZE_BIT])
    begin
      hall_out = hall_inverse(hall_mag);
    end
    else
    begin
      hall_out = hall_mag;
    end
    near_hit    = hall_en && (hall_out > level_scale(s_r.near_level_r));
    contact_hit = hall_en && (hall_out > level_scale(s_r.contact_level_r));
    // A change of either switch output is one Hall event; the host sees
    // it only as a flip of the toggle bit, never as a sticky flag
    hall_change = (near_hit != s_r.hall_near_r) || (contact_hit != s_r.hall_contact_r);
    // Event pulse and level change are ORed, so a coincident pair
    // cannot cancel into no flip at all
    sar_change  = SAR_QUALIFIED_EVENT || (SAR_DETECT_LEVEL != s_r.sar_level_prev_r);

    // Mode code 3 has no layout of its own and reads as standard
    chan_view   = 8'h00;
    detail_view = 8'h00;
    if (ui_mode == SEFB_UI_DUAL_SAR)
    begin
      chan_view[SEFB_DA_ANT1_NEAR]      = ANT1_NEAR;
      chan_view[SEFB_DA_ANT2_NEAR]      = ANT2_NEAR;
      chan_view[SEFB_DA_ANT1_CONTACT]   = ANT1_CONTACT;
      chan_view[SEFB_DA_ANT1_DEEP]      = ANT1_DEEP;
      detail_view[SEFB_DA_ANT2_CONTACT] = ANT2_CONTACT;
      detail_view[SEFB_DA_ANT2_DEEP]    = ANT2_DEEP;
    end
    else
    begin
      chan_view[SEFB_CF_NEAR_LSB +: 3]    = CHAN_NEAR;
      chan_view[SEFB_CF_CONTACT_LSB +: 3] = CHAN_CONTACT;
      detail_view[SEFB_HY_NEAR]           = HYST_CH2_NEAR;
      detail_view[SEFB_HY_CONTACT]        = HYST_CH2_CONTACT;
      detail_view[SEFB_HY_SIGNED]         = HYST_CH2_SIGNED;
      if (ui_mode == SEFB_UI_SINGLE_SAR)
      begin
        detail_view[SEFB_SD_SAR_OUTPUT]    = SAR_DETECT_LEVEL;
        detail_view[SEFB_SD_QUICK_RELEASE] = SAR_QUICK_RELEASE;
        detail_view[SEFB_SD_MOVEMENT]      = SAR_MOVEMENT;
        detail_view[SEFB_SD_FILTER_HALTED] = SAR_FILTER_HALTED;
      end
    end

    // Toggles are never cleared by a read: polling has no side effect, and
    // the host finds a new event by comparing with its previous poll
    global_view = 8'h00;
    global_view[SEFB_GE_CAP_ACTIVITY_BIT] = (|CHAN_NEAR) | (|CHAN_CONTACT);
    global_view[SEFB_GE_SAR_TOGGLE_BIT]   = s_r.sar_toggle_r;
    global_view[SEFB_GE_HALL_TOGGLE_BIT]  = s_r.hall_toggle_r;
    global_view[SEFB_GE_HYST_BIT]         = HYST_CH2_NEAR | HYST_CH2_CONTACT;
    global_view[SEFB_GE_TEMP_BIT]         = TEMP_EVENT;
    global_view[SEFB_GE_SYSTEM_BIT]       = SYSTEM_EVENT;
    global_view[SEFB_GE_POWER_BIT]        = POWER_MANAGER_EVENT;
    global_view[SEFB_GE_SAR_LEVEL_BIT]    = SAR_DETECT_LEVEL;
  end

  // ===========================================================
  // Next state
  always_comb
  begin
    s_nxt = s_r;

    // Only the Hall settings accept writes; flag registers ignore them
    if (REG_WR_EN)
    begin
      unique case (REG_ADDR)
        SEFB_HALL_RATE_TUNING_CONFIG_OFS: s_nxt.rate_cfg_r      = REG_WR_DATA;
        SEFB_HALL_TUNING_BASE_TARGET_OFS: s_nxt.tuning_cfg_r    = REG_WR_DATA;
        SEFB_HALL_SWITCH_CONFIG_OFS:      s_nxt.switch_cfg_r    = REG_WR_DATA;
        SEFB_HALL_SWITCH_NEAR_LEVEL_OFS:  s_nxt.near_level_r    = REG_WR_DATA;
        SEFB_HALL_SWITCH_CONTACT_OFS:     s_nxt.contact_level_r = REG_WR_DATA;
        default:                          s_nxt.rd_data_r       = s_r.rd_data_r;
      endcase
    end

    // Hall switch result, with a toggle on every change of its near or contact output
    s_nxt.hall_amp_r     = hall_out;
    s_nxt.hall_near_r    = near_hit;
    s_nxt.hall_contact_r = contact_hit;
    // North is reported for a zero difference as well
    s_nxt.hall_south_r   = hall_en & hall_diff[HALL_W];
    if (hall_change)
    begin
      s_nxt.hall_toggle_r = ~s_r.hall_toggle_r;
    end

    // A qualified event and a status change in the same cycle give one toggle
    s_nxt.sar_level_prev_r = SAR_DETECT_LEVEL;
    if (sar_change)
    begin
      s_nxt.sar_toggle_r = ~s_r.sar_toggle_r;
    end

    // Read data is registered: it reflects the address of the previous cycle
    // Unmapped addresses read as zero so a stray poll is harmless
    unique case (REG_ADDR)
      SEFB_GLOBAL_EVENT_SUMMARY_OFS:    s_nxt.rd_data_r = global_view;
      SEFB_CHANNEL_PROX_TOUCH_OFS:      s_nxt.rd_data_r = chan_view;
      SEFB_DETAIL_FLAGS_OFS:            s_nxt.rd_data_r = detail_view;
      SEFB_HALL_RATE_TUNING_CONFIG_OFS: s_nxt.rd_data_r = s_r.rate_cfg_r;
      SEFB_HALL_TUNING_BASE_TARGET_OFS: s_nxt.rd_data_r = s_r.tuning_cfg_r;
      SEFB_HALL_SWITCH_CONFIG_OFS:      s_nxt.rd_data_r = s_r.switch_cfg_r;
      SEFB_HALL_SWITCH_NEAR_LEVEL_OFS:  s_nxt.rd_data_r = s_r.near_level_r;
      SEFB_HALL_SWITCH_CONTACT_OFS:     s_nxt.rd_data_r = s_r.contact_level_r;
      default:                          s_nxt.rd_data_r = 8'h00;
    endcase
  end

  // ===========================================================
  // Registers
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      // Flags and read data clear; the settings take their defaults
      s_r                 <= '0;
      s_r.rate_cfg_r      <= SEFB_HALL_RATE_RST;
      s_r.tuning_cfg_r    <= SEFB_HALL_TUNING_RST;
      s_r.switch_cfg_r    <= SEFB_HALL_SWITCH_RST;
      s_r.near_level_r    <= SEFB_HALL_NEAR_RST;
      s_r.contact_level_r <= SEFB_HALL_CONTACT_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ===========================================================
  // Outputs
  // Tuning base/target are passed through as written; ordering them is the
  // host's job, and the front end simply fails to tune otherwise.
  // Every output comes straight from a flip-flop of the state
  assign REG_RD_DATA             = s_r.rd_data_r;
  assign HALL_CHARGE_DIV         = s_r.rate_cfg_r[SEFB_HR_DIV_LSB +: SEFB_HR_DIV_W];
  assign HALL_AUTO_TUNING_MODE   = s_r.rate_cfg_r[SEFB_HR_TUNE_LSB +: SEFB_HR_TUNE_W];
  assign HALL_AUTO_TUNING_BASE   = s_r.tuning_cfg_r[SEFB_HT_BASE_LSB +: SEFB_HT_FIELD_W];
  assign HALL_AUTO_TUNING_TARGET = s_r.tuning_cfg_r[SEFB_HT_TARGET_LSB +: SEFB_HT_FIELD_W];
  assign HALL_AMPLITUDE          = s_r.hall_amp_r;
  assign HALL_NEAR               = s_r.hall_near_r;
  assign HALL_CONTACT            = s_r.hall_contact_r;
  assign HALL_SOUTH              = s_r.hall_south_r;

endmodule

// ===== verilog/sefb_pkg.sv
/*
  Shared constants of the sensor event flag bank: register offsets, field
  positions, reset values and the user-interface mode encoding.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sefb_pkg;

  // ===========================================================
  // Register offsets
  localparam logic [7:0] SEFB_GLOBAL_EVENT_SUMMARY_OFS    = 8'h11;
  localparam logic [7:0] SEFB_CHANNEL_PROX_TOUCH_OFS      = 8'h12;
  localparam logic [7:0] SEFB_DETAIL_FLAGS_OFS            = 8'h13;
  localparam logic [7:0] SEFB_HALL_RATE_TUNING_CONFIG_OFS = 8'h90;
  localparam logic [7:0] SEFB_HALL_TUNING_BASE_TARGET_OFS = 8'h91;
  localparam logic [7:0] SEFB_HALL_SWITCH_CONFIG_OFS      = 8'hA0;
  localparam logic [7:0] SEFB_HALL_SWITCH_NEAR_LEVEL_OFS  = 8'hA1;
  localparam logic [7:0] SEFB_HALL_SWITCH_CONTACT_OFS     = 8'hA2;

  // ===========================================================
  // Global event summary bit positions
  localparam int SEFB_GE_CAP_ACTIVITY_BIT = 0;
  localparam int SEFB_GE_SAR_TOGGLE_BIT   = 1;
  localparam int SEFB_GE_HALL_TOGGLE_BIT  = 2;
  localparam int SEFB_GE_HYST_BIT         = 3;
  localparam int SEFB_GE_TEMP_BIT         = 4;
  localparam int SEFB_GE_SYSTEM_BIT       = 5;
  localparam int SEFB_GE_POWER_BIT        = 6;
  localparam int SEFB_GE_SAR_LEVEL_BIT    = 7;

  // ===========================================================
  // Channel flag register (standard and two-antenna layouts; antenna 2 contact/deep go to 0x13)
  localparam int SEFB_CF_NEAR_LSB     = 0;
  localparam int SEFB_CF_CONTACT_LSB  = 4;
  localparam int SEFB_DA_ANT1_NEAR    = 0;
  localparam int SEFB_DA_ANT2_NEAR    = 2;
  localparam int SEFB_DA_ANT1_CONTACT = 4;
  localparam int SEFB_DA_ANT1_DEEP    = 5;
  localparam int SEFB_DA_ANT2_CONTACT = 5;
  localparam int SEFB_DA_ANT2_DEEP    = 6;

  // ===========================================================
  // Detail flag register (single SAR and hysteresis layouts)
  localparam int SEFB_SD_FILTER_HALTED = 0;
  localparam int SEFB_SD_MOVEMENT      = 1;
  localparam int SEFB_SD_QUICK_RELEASE = 2;
  localparam int SEFB_SD_SAR_OUTPUT    = 4;
  localparam int SEFB_HY_NEAR          = 5;
  localparam int SEFB_HY_CONTACT       = 6;
  localparam int SEFB_HY_SIGNED        = 7;

  // ===========================================================
  // Hall settings fields
  localparam int SEFB_HR_DIV_LSB       = 0;
  localparam int SEFB_HR_DIV_W         = 4;
  localparam int SEFB_HR_TUNE_LSB      = 4;
  localparam int SEFB_HR_TUNE_W        = 2;
  localparam int SEFB_HT_BASE_LSB      = 0;
  localparam int SEFB_HT_TARGET_LSB    = 4;
  localparam int SEFB_HT_FIELD_W       = 4;
  localparam int SEFB_HS_ENABLE_BIT    = 0;
  localparam int SEFB_HS_LINEARIZE_BIT = 1;
  localparam int SEFB_HALL_THR_SHIFT   = 4;

  // ===========================================================
  // Reset values
  localparam logic [7:0] SEFB_HALL_RATE_RST    = 8'h00;
  localparam logic [7:0] SEFB_HALL_TUNING_RST  = 8'h40;
  localparam logic [7:0] SEFB_HALL_SWITCH_RST  = 8'h01;
  localparam logic [7:0] SEFB_HALL_NEAR_RST    = 8'h10;
  localparam logic [7:0] SEFB_HALL_CONTACT_RST = 8'h40;
  localparam logic [15:0] SEFB_HALL_INV_NUMER  = 16'hFFFF;

  // ===========================================================
  // User-interface mode of the capacitive channels
  typedef enum logic [1:0] {
    SEFB_UI_STANDARD   = 2'h0,
    SEFB_UI_SINGLE_SAR = 2'h1,
    SEFB_UI_DUAL_SAR   = 2'h2
  } sefb_ui_mode_t;

endpackage

// ===== tb/sefb_bank_properties.sv
/* Checker of the flag bank read port: read data one clock after the address.
   Bound to every sefb_bank; sees only its ports. */
`timescale 1ns/100ps
module sefb_bank_properties
(
  input logic       CLK,
  input logic       RST_B,
  input logic [7:0] REG_ADDR,
  input logic       REG_WR_EN,
  input logic [7:0] REG_RD_DATA,
  input logic [1:0] UI_MODE,
  input logic [2:0] CHAN_NEAR,
  input logic [2:0] CHAN_CONTACT,
  input logic       SAR_DETECT_LEVEL,
  input logic       SAR_QUALIFIED_EVENT,
  input logic       SAR_QUICK_RELEASE,
  input logic       SAR_MOVEMENT,
  input logic       SAR_FILTER_HALTED,
  input logic       HYST_CH2_NEAR,
  input logic       HYST_CH2_CONTACT,
  input logic       TEMP_EVENT,
  input logic       SYSTEM_EVENT,
  input logic       POWER_MANAGER_EVENT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // ==========================================================
  // Read data layouts
  property p_cap; REG_ADDR == 8'h11 |=> REG_RD_DATA[0] == $past(|{CHAN_NEAR, CHAN_CONTACT}); endproperty
  a_cap: assert property (p_cap) else $error("activity bit wrong");
  property p_lvl; REG_ADDR == 8'h11 |=> REG_RD_DATA[7] == $past(SAR_DETECT_LEVEL); endproperty
  a_lvl: assert property (p_lvl) else $error("sar level bit wrong");
  // Event and read in one cycle: the flip shows on the read one cycle later
  property p_tog;
    (REG_ADDR == 8'h11 && SAR_QUALIFIED_EVENT) ##1 REG_ADDR == 8'h11 |=> $changed(REG_RD_DATA[1]); endproperty
  a_tog: assert property (p_tog) else $error("sar toggle did not flip");
  property p_hys; REG_ADDR == 8'h11 |=> REG_RD_DATA[3] == $past(HYST_CH2_NEAR | HYST_CH2_CONTACT); endproperty
  a_hys: assert property (p_hys) else $error("hysteresis bit wrong");
  property p_misc;
    REG_ADDR == 8'h11 |=> REG_RD_DATA[6:4] == $past({POWER_MANAGER_EVENT, SYSTEM_EVENT, TEMP_EVENT}); endproperty
  a_misc: assert property (p_misc) else $error("other event bits wrong");
  property p_chan;
    REG_ADDR == 8'h12 && UI_MODE != 2'h2 |=> REG_RD_DATA == $past({1'b0, CHAN_CONTACT, 1'b0, CHAN_NEAR}); endproperty
  a_chan: assert property (p_chan) else $error("channel flags wrong");
  property p_sar;
    REG_ADDR == 8'h13 && UI_MODE == 2'h1 |=> REG_RD_DATA[4:0] ==
      $past({SAR_DETECT_LEVEL, 1'b0, SAR_QUICK_RELEASE, SAR_MOVEMENT, SAR_FILTER_HALTED}); endproperty
  a_sar: assert property (p_sar) else $error("sar detail flags wrong");
  property p_std; REG_ADDR == 8'h13 && UI_MODE == 2'h0 |=> REG_RD_DATA[4:0] == 5'h00; endproperty
  a_std: assert property (p_std) else $error("sar detail shown outside sar mode");
  c_wr: cover property (REG_WR_EN && REG_ADDR == 8'hA1);
  c_tog: cover property (SAR_QUALIFIED_EVENT && REG_ADDR == 8'h11);
  c_dual: cover property (REG_ADDR == 8'h13 && UI_MODE == 2'h2);
endmodule
bind sefb_bank sefb_bank_properties i_props (.CLK(CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR),
  .REG_WR_EN(REG_WR_EN), .REG_RD_DATA(REG_RD_DATA), .UI_MODE(UI_MODE), .CHAN_NEAR(CHAN_NEAR),
  .CHAN_CONTACT(CHAN_CONTACT), .SAR_DETECT_LEVEL(SAR_DETECT_LEVEL), .SAR_QUALIFIED_EVENT(SAR_QUALIFIED_EVENT),
  .SAR_QUICK_RELEASE(SAR_QUICK_RELEASE), .SAR_MOVEMENT(SAR_MOVEMENT), .SAR_FILTER_HALTED(SAR_FILTER_HALTED),
  .HYST_CH2_NEAR(HYST_CH2_NEAR), .HYST_CH2_CONTACT(HYST_CH2_CONTACT), .TEMP_EVENT(TEMP_EVENT),
  .SYSTEM_EVENT(SYSTEM_EVENT), .POWER_MANAGER_EVENT(POWER_MANAGER_EVENT));

// ===== tb/sefb_host.sv
/* Host model: polls and writes the bank registers over its byte port.
   Assumes read data comes one clock after the address is sampled. */
`timescale 1ns/100ps
module sefb_host
(
  input  logic       CLK,
  output logic [7:0] REG_ADDR,
  output logic       REG_WR_EN,
  output logic [7:0] REG_WR_DATA,
  input  logic [7:0] REG_RD_DATA
);
  initial {REG_ADDR, REG_WR_EN, REG_WR_DATA} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK) #1 {REG_ADDR, REG_WR_EN, REG_WR_DATA} = {a, 1'b1, d};
    // Data inverted after the strobe so a stale value never passes for a write
    @(posedge CLK) #1 {REG_WR_EN, REG_WR_DATA} = {1'b0, ~d};
  endtask
  // Toggle flags are judged by the caller against its previous poll
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK) #1 REG_ADDR = a;
    @(posedge CLK) #1 d = REG_RD_DATA;
  endtask
endmodule

// ===== tb/sefb_bank_tb.sv
/* Testbench of the sensor event flag bank: host model on the register port,
   sensing inputs driven by the bench one delay after CLK. */
`timescale 1ns/100ps
module sefb_bank_tb;
  logic        clk = 1'b0;
  logic        rst_b, reg_wr_en, h_near, h_con, h_south;
  logic [7:0]  reg_addr, reg_wr_data, reg_rd_data;
  logic [1:0]  ui_mode, tmode;
  logic [3:0]  div, base, tgt;
  logic [15:0] ch4, ch5, amp;
  logic [22:0] f;
  int          fails = 0, n_checks = 0, cycles = 0;
  sefb_bank #(.HALL_W(16)) i_dut (.CLK(clk), .RST_B(rst_b), .REG_ADDR(reg_addr), .REG_WR_EN(reg_wr_en),
    .REG_WR_DATA(reg_wr_data), .REG_RD_DATA(reg_rd_data), .UI_MODE(ui_mode), .CHAN_NEAR(f[2:0]),
    .CHAN_CONTACT(f[5:3]), .SAR_DETECT_LEVEL(f[6]), .SAR_QUALIFIED_EVENT(f[7]), .SAR_QUICK_RELEASE(f[8]),
    .SAR_MOVEMENT(f[9]), .SAR_FILTER_HALTED(f[10]), .ANT1_NEAR(f[11]), .ANT1_CONTACT(f[12]), .ANT1_DEEP(f[13]),
    .ANT2_NEAR(f[14]), .ANT2_CONTACT(f[15]), .ANT2_DEEP(f[16]), .HYST_CH2_NEAR(f[17]), .HYST_CH2_CONTACT(f[18]),
    .HYST_CH2_SIGNED(f[19]), .TEMP_EVENT(f[20]), .SYSTEM_EVENT(f[21]), .POWER_MANAGER_EVENT(f[22]),
    .HALL_CH4_POS(ch4), .HALL_CH5_NEG(ch5), .HALL_CHARGE_DIV(div), .HALL_AUTO_TUNING_MODE(tmode),
    .HALL_AUTO_TUNING_BASE(base), .HALL_AUTO_TUNING_TARGET(tgt), .HALL_AMPLITUDE(amp), .HALL_NEAR(h_near),
    .HALL_CONTACT(h_con), .HALL_SOUTH(h_south));
  sefb_host i_host (.CLK(clk), .REG_ADDR(reg_addr), .REG_WR_EN(reg_wr_en), .REG_WR_DATA(reg_wr_data),
    .REG_RD_DATA(reg_rd_data));
  initial forever #20 clk = ~clk;
  always @(posedge clk) cycles <= cycles + 1;
  always @(posedge clk) if (cycles == 3000) test_done(1);
  // ==========================================================
  // Checking and closing
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) fails++;
    if (seen !== exp) $display("unexpected %s: expected %h seen %h", nm, exp, seen);
  endtask
  task automatic test_done(input int extra);
    fails += extra;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    logic [7:0] a [5] = '{8'h90, 8'h91, 8'hA0, 8'hA1, 8'hA2};
    logic [7:0] rv [5] = '{8'h00, 8'h40, 8'h01, 8'h10, 8'h40};
    logic [7:0] pv [5] = '{8'h2B, 8'h93, 8'h01, 8'h20, 8'h60};
    logic [7:0] d;
    for (int i = 0; i < 5; i++)
    begin
      i_host.rd(a[i], d);
      chk("reset value", {8'h00, d}, {8'h00, rv[i]});
      i_host.wr(a[i], pv[i]);
      i_host.rd(a[i], d);
      chk("read back", {8'h00, d}, {8'h00, pv[i]});
    end
    chk("tuning outputs", {2'h0, div, tmode, base, tgt}, 16'h2E39);
    i_host.wr(8'h11, 8'hFF);
    i_host.rd(8'h11, d);
    chk("summary after write", {8'h00, d & 8'hF9}, 16'h0000);
    i_host.rd(8'h55, d);
    chk("unmapped read", {8'h00, d}, 16'h0000);
  endtask
  task automatic t_modes;
    logic [7:0] d, e11, e12, e13;
    for (int m = 0; m < 8; m++)
    begin
      ui_mode = m[1:0];
      f = m[2] ? 23'h25492A : 23'h5AB655;
      e12 = (m[1:0] == 2'h2) ? {2'h0, f[13:12], 1'b0, f[14], 1'b0, f[11]} : {1'b0, f[5:3], 1'b0, f[2:0]};
      e13 = (m[1:0] == 2'h2) ? {1'b0, f[16:15], 5'h00}
          : {f[19:17], (m[1:0] == 2'h1) ? {f[6], 1'b0, f[8], f[9], f[10]} : 5'h00};
      e11 = {f[6], f[22:20], f[17] | f[18], 2'b00, |f[5:0]};
      i_host.rd(8'h12, d);
      chk("channel flags", {8'h00, d}, {8'h00, e12});
      i_host.rd(8'h13, d);
      chk("detail flags", {8'h00, d}, {8'h00, e13});
      // Toggle bits are masked: they carry history, not the present inputs
      i_host.rd(8'h11, d);
      chk("global events", {8'h00, d & 8'hF9}, {8'h00, e11});
    end
  endtask
  task automatic t_sar;
    logic [7:0] d;
    logic       t;
    f = 23'h0;
    i_host.rd(8'h11, d);
    t = d[1];
    f = 23'h80;
    @(posedge clk) #1 f = 23'h0;
    i_host.rd(8'h11, d);
    chk("sar after event", {14'h0, d[7], d[1]}, {14'h0, 1'b0, ~t});
    f = 23'h40;
    i_host.rd(8'h11, d);
    chk("sar on detect", {14'h0, d[7], d[1]}, {14'h0, 1'b1, t});
    i_host.rd(8'h11, d);
    chk("sar held", {14'h0, d[7], d[1]}, {14'h0, 1'b1, t});
    // Event and release in one cycle must flip the toggle once only
    f = 23'h80;
    @(posedge clk) #1 f = 23'h0;
    i_host.rd(8'h11, d);
    chk("sar_change_toggle with release", {14'h0, d[7], d[1]}, {14'h0, 1'b0, ~t});
  endtask
  task automatic t_hall;
    logic [7:0]  cf [7] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h03, 8'h03, 8'h00};
    logic [15:0] p4 [7] = '{16'h1000, 16'h0100, 16'h0A00, 16'h0A01, 16'h1000, 16'h0500, 16'h0100};
    logic [15:0] p5 [7] = '{16'h0C00, 16'h0900, 16'h0800, 16'h0800, 16'h0C00, 16'h0500, 16'h0900};
    logic [15:0] ea [7] = '{16'h0400, 16'h0800, 16'h0200, 16'h0201, 16'h003F, 16'hFFFF, 16'h0800};
    logic [2:0]  ef [7] = '{3'h4, 3'h7, 3'h0, 3'h4, 3'h0, 3'h6, 3'h0};
    logic [7:0]  d;
    logic        ht;
    logic [1:0]  pnc;
    // Baseline poll: the Hall toggle is judged against the previous read
    i_host.rd(8'h11, d);
    ht = d[2];
    pnc = 2'b00;
    for (int i = 0; i < 7; i++)
    begin
      i_host.wr(8'hA0, cf[i]);
      {ch4, ch5} = {p4[i], p5[i]};
      repeat (2) @(posedge clk);
      #1 chk("hall amplitude", amp, ea[i]);
      chk("hall switch", {13'h0, h_near, h_con, h_south}, {13'h0, ef[i]});
      i_host.rd(8'h11, d);
      if (ef[i][2:1] != pnc)
      begin
        ht = ~ht;
      end
      chk("hall toggle", {15'h0, d[2]}, {15'h0, ht});
      pnc = ef[i][2:1];
    end
  endtask
  initial
  begin
    {rst_b, f, ui_mode, ch4, ch5} = '0;
    repeat (16) @(posedge clk);
    #1 rst_b = 1'b1;
    t_regs;
    t_modes;
    t_sar;
    t_hall;
    test_done(0);
  end
endmodule
